// File: rtl/liucfg_pkg.sv
package liucfg_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam int         NUM_CHAN      = 8;
  localparam int         MEM_DEPTH     = 254;
  localparam logic [7:0] OFS_CHAN_LAST = 8'h7F;
  localparam logic [7:0] OFS_GLB_A     = 8'h80;
  localparam logic [7:0] OFS_GLB_B     = 8'h81;
  localparam logic [7:0] OFS_PIN_OVR   = 8'h82;
  localparam logic [7:0] OFS_SLICER    = 8'h83;
  localparam logic [7:0] OFS_LCV_SEL   = 8'h8C;
  localparam logic [7:0] OFS_LCV_CTRL  = 8'h8D;
  localparam logic [7:0] OFS_LCV_READ  = 8'h8E;
  localparam logic [7:0] OFS_E1_ARB    = 8'hC0;
  localparam logic [7:0] OFS_DEV_ID    = 8'hFE;
  localparam logic [7:0] OFS_DEV_REV   = 8'hFF;
  localparam logic [3:0] SUB_PATTERN   = 4'h0;
  localparam logic [3:0] SUB_TERM      = 4'h1;
  localparam logic [3:0] SUB_TEST      = 4'h2;
  localparam logic [3:0] SUB_CODING    = 4'h3;
  localparam logic [3:0] SUB_IRQ_EN    = 4'h4;
  localparam logic [3:0] SUB_STATUS    = 4'h5;
  localparam logic [3:0] SUB_IRQ_STAT  = 4'h6;
  localparam logic [3:0] SUB_SPARE     = 4'h7;
  localparam logic [7:0] RESET_VALUE   = 8'h00;

  // ********************************************************************
  // Writable bit masks; masked bits read as zero, except at OFS_LCV_READ, OFS_DEV_ID and OFS_DEV_REV.
  // ********************************************************************
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam logic [7:0] MASK_NONE     = 8'h00;
  localparam logic [7:0] MASK_CODING   = 8'h3E;
  localparam logic [7:0] MASK_IRQ_EN   = 8'h77;
  localparam logic [7:0] MASK_SEGMENT  = 8'h7F;
  localparam logic [7:0] MASK_GLB_A    = 8'hFB;
  localparam logic [7:0] MASK_PIN_OVR  = 8'hC0;
  localparam logic [7:0] MASK_SLICER   = 8'h0C;
  localparam logic [7:0] MASK_LCV_SEL  = 8'h0F;
  localparam logic [7:0] MASK_LCV_CTRL = 8'h1F;
  localparam logic [7:0] MASK_E1_ARB   = 8'h01;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int BIT_QRSS      = 7;
  localparam int BIT_ROUTE     = 6;
  localparam int BIT_RECEIVER_POWER_ON      = 5;
  localparam int CODE_MSB      = 4;
  localparam int BIT_RX_TERM   = 7;
  localparam int BIT_TX_TERM   = 6;
  localparam int IMP_MSB       = 5;
  localparam int IMP_LSB       = 4;
  localparam int JA_MSB        = 3;
  localparam int JA_LSB        = 2;
  localparam int LCV_CH_MSB    = 3;
  localparam int BIT_CLR_ALL   = 4;
  localparam int BIT_BYTE_SEL  = 2;
  localparam int BIT_CLR_CHAN  = 0;
  localparam int BIT_E1_ARB    = 0;

  // ********************************************************************
  // Cable length codes.
  // ********************************************************************
  localparam logic [4:0] CODE_T1_FIRST = 5'h08;
  localparam logic [4:0] CODE_T1_LAST  = 5'h0C;
  localparam logic [4:0] CODE_T1_ARB   = 5'h0D;
  localparam logic [4:0] CODE_E1_COAX  = 5'h1C;
  localparam logic [4:0] CODE_E1_TP    = 5'h1D;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

  typedef enum logic [1:0] {LM_NONE = 2'h0, LM_T1 = 2'h1, LM_E1 = 2'h2} liucfg_mode_t;
  typedef enum logic [1:0] {IMP_100 = 2'h0, IMP_110 = 2'h1, IMP_75 = 2'h2, IMP_120 = 2'h3} liucfg_imp_t;
  typedef enum logic [1:0] {JA_OFF = 2'h0, JA_TX = 2'h1, JA_RX = 2'h2} liucfg_ja_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_HOLD = 2'b10} liucfg_bus_state_t;

  // Decoded settings of one channel.
  typedef struct packed {
    logic         qrss;
    logic         route_rx;
    logic         rx_power;
    liucfg_mode_t mode;
    logic [2:0]   build_out;
    logic         arbitrary;
    logic         hdb3;
    liucfg_imp_t  cable;
    liucfg_imp_t  impedance;
    liucfg_ja_t   jitter;
    logic         rx_term;
    logic         tx_term;
  } liucfg_chan_t;

  // Parallel port pins as seen from the device.
  typedef struct packed {
    logic       cs_n;
    logic       as_n;
    logic       ds_n;
    logic       rd_wr_n;
    logic [7:0] addr;
    logic [7:0] data;
  } liucfg_bus_t;

endpackage

// File: rtl/liucfg_regs.sv
// What this block does
// RQ1: Bit 7 picks QRSS or PRBS pattern.
// RQ2: Bit 6 routes generator to line or receive.
// RQ3: Software keeps route bit zero when idle.
// RQ4: Receivers off at reset; bit 5 powers.
// RQ5: Receive enable pin low forces receivers off.
// RQ6: Bits 4:0 are cable code, reset zero.
// RQ7: Codes 08-0C T1 build-outs, 0D arbitrary.
// RQ8: Code 1C E1 coax, 1D E1 pair.
// RQ9: Impedance field selects 100/110/75/120 ohms.
// RQ10: Channels 1-7 repeat channel 0 block.
// RQ11: Test area 8F-FD is plain storage, except C0.
// RQ12: Jitter field: off, transmit, receive path.
// RQ13: Readout gives chosen byte of chosen counter.
// RQ14: Reserved bits zero; read-only writes ignored.
`timescale 1ns/1ns
`default_nettype none
module liucfg_regs #(
  parameter logic [7:0] DEVICE_IDENTIFIER  = 8'h5A,
  parameter logic [7:0] DEVICE_REV = 8'h01
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire liucfg_pkg::liucfg_bus_t bus_i,
  output logic [7:0]                 data_o,
  output logic                       data_oe_o,
  output logic                       dtack_n_o,
  input  wire logic                  receiver_enable_i,
  input  wire logic [7:0]            violation_i,
  input  wire logic [7:0]            generator_enable_i,
  input  wire logic [7:0]            generator_bit_i,
  input  wire logic [7:0]            tx_pos_i,
  input  wire logic [7:0]            tx_neg_i,
  input  wire logic [7:0]            rx_pos_i,
  input  wire logic [7:0]            rx_neg_i,
  output liucfg_pkg::liucfg_chan_t   chan_cfg_o [8],
  output logic [7:0]                 receiver_power_on_o,
  output logic [7:0]                 transmit_line_tip_o,
  output logic [7:0]                 transmit_line_ring_o,
  output logic [7:0]                 receive_positive_data_o,
  output logic [7:0]                 receive_negative_data_o,
  output logic                       e1_arbitrary_pulse_enable_o
);
  import liucfg_pkg::*;

  // The identity values above are arbitrary.

  // ******************************************************************
  // State.
  // ******************************************************************
  liucfg_bus_t       bus_meta_ff;
  liucfg_bus_t       bus_sync_ff;
  logic              rx_en_meta_ff;
  logic              rx_en_sync_ff;
  liucfg_bus_state_t state_ff;
  liucfg_bus_state_t nxt_state;
  logic [7:0]        addr_ff;
  logic [7:0]        nxt_addr;
  logic [7:0]        rdata_ff;
  logic [7:0]        nxt_rdata;
  logic              read_ff;
  logic              nxt_read;
  logic [7:0]        mem_ff [MEM_DEPTH];
  logic [7:0]        nxt_mem [MEM_DEPTH];
  logic [15:0]       count_ff [NUM_CHAN];
  logic [15:0]       nxt_count [NUM_CHAN];
  liucfg_chan_t      cfg_ff [NUM_CHAN];
  liucfg_chan_t      nxt_cfg [NUM_CHAN];
  logic [7:0]        pwr_ff;
  logic [7:0]        nxt_pwr;
  logic [7:0]        tip_ff;
  logic [7:0]        nxt_tip;
  logic [7:0]        ring_ff;
  logic [7:0]        nxt_ring;
  logic [7:0]        receive_positive_data_ff;
  logic [7:0]        nxt_receive_positive_data;
  logic [7:0]        receive_negative_data_ff;
  logic [7:0]        nxt_receive_negative_data;
  logic              access;
  logic              wr_ctrl;

  // Writable bits of each address; reserved and read-only bits are zero.
  function automatic logic [7:0] write_mask(input logic [7:0] a);
    logic [7:0] m;
    m = MASK_FULL;
    if (a <= OFS_CHAN_LAST) begin  // [RQ10]
      unique case (a[3:0])
        SUB_CODING:                       m = MASK_CODING;
        SUB_IRQ_EN:                       m = MASK_IRQ_EN;
        SUB_STATUS, SUB_IRQ_STAT, SUB_SPARE: m = MASK_NONE;
        SUB_PATTERN, SUB_TERM, SUB_TEST:  m = MASK_FULL;
        default:                          m = MASK_SEGMENT;
      endcase
    end else begin
      unique case (a)
        OFS_GLB_A:    m = MASK_GLB_A;
        OFS_PIN_OVR:  m = MASK_PIN_OVR;
        OFS_SLICER:   m = MASK_SLICER;
        OFS_LCV_SEL:  m = MASK_LCV_SEL;
        OFS_LCV_CTRL: m = MASK_LCV_CTRL;
        OFS_E1_ARB:   m = MASK_E1_ARB;
        OFS_LCV_READ, OFS_DEV_ID, OFS_DEV_REV: m = MASK_NONE;  // [RQ14]
        default:      m = MASK_FULL;  // [RQ11]
      endcase
    end
    return m;
  endfunction

  // ******************************************************************
  // Pin synchronisers.
  // ******************************************************************
  // The bus pins and the receive enable pin pass two flip-flops before any logic sees them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_meta_ff   <= '{cs_n: 1'b1, as_n: 1'b1, ds_n: 1'b1, rd_wr_n: 1'b1, addr: 8'h00, data: 8'h00};
      bus_sync_ff   <= '{cs_n: 1'b1, as_n: 1'b1, ds_n: 1'b1, rd_wr_n: 1'b1, addr: 8'h00, data: 8'h00};
      rx_en_meta_ff <= 1'b0;
      rx_en_sync_ff <= 1'b0;
    end else begin
      bus_meta_ff   <= bus_i;
      bus_sync_ff   <= bus_meta_ff;
      rx_en_meta_ff <= receiver_enable_i;
      rx_en_sync_ff <= rx_en_meta_ff;
    end
  end

  // ******************************************************************
  // Port handshake and register file.
  // ******************************************************************
  // One access per data strobe; the acknowledge holds until the strobe ends.
  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_rdata = rdata_ff;
    nxt_read  = read_ff;
    nxt_mem   = mem_ff;
    access    = 1'b0;
    wr_ctrl   = 1'b0;
    if (!bus_sync_ff.cs_n && !bus_sync_ff.as_n) begin
      nxt_addr = bus_sync_ff.addr;
    end
    unique case (state_ff)
      BUS_IDLE: begin
        if (!bus_sync_ff.cs_n && !bus_sync_ff.ds_n) begin
          access    = 1'b1;
          nxt_state = BUS_HOLD;
          nxt_read  = bus_sync_ff.rd_wr_n;
        end
      end
      BUS_HOLD: begin
        if (bus_sync_ff.ds_n || bus_sync_ff.cs_n) begin
          nxt_state = BUS_IDLE;
          nxt_read  = 1'b0;
        end
      end
      default: begin
        nxt_state = BUS_IDLE;
        nxt_read  = 1'b0;
      end
    endcase
    if (access && bus_sync_ff.rd_wr_n) begin
      unique case (addr_ff)
        OFS_DEV_ID:   nxt_rdata = DEVICE_IDENTIFIER;
        OFS_DEV_REV:  nxt_rdata = DEVICE_REV;
        OFS_LCV_READ: begin  // [RQ13]
          nxt_rdata = 8'h00;
          if (mem_ff[OFS_LCV_SEL][LCV_CH_MSB] == 1'b0) begin
            nxt_rdata = mem_ff[OFS_LCV_CTRL][BIT_BYTE_SEL]
                      ? count_ff[mem_ff[OFS_LCV_SEL][2:0]][15:8]
                      : count_ff[mem_ff[OFS_LCV_SEL][2:0]][7:0];
          end
        end
        default:      nxt_rdata = mem_ff[addr_ff] & write_mask(addr_ff);  // [RQ14]
      endcase
    end
    if (access && !bus_sync_ff.rd_wr_n && addr_ff < MEM_DEPTH[7:0]) begin
      nxt_mem[addr_ff] = bus_sync_ff.data & write_mask(addr_ff);  // [RQ14]
      wr_ctrl = (addr_ff == OFS_LCV_CTRL);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= BUS_IDLE;
      addr_ff  <= 8'h00;
      rdata_ff <= 8'h00;
      read_ff  <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_ff[i] <= RESET_VALUE;  // [RQ4] [RQ6]
      end
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      rdata_ff <= nxt_rdata;
      read_ff  <= nxt_read;
      mem_ff   <= nxt_mem;
    end
  end

  // ******************************************************************
  // Violation counters.
  // ******************************************************************
  // A clear and a violation in one cycle leave a count of one.
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      nxt_count[c] = count_ff[c];
      if (wr_ctrl && (bus_sync_ff.data[BIT_CLR_ALL] ||
          (bus_sync_ff.data[BIT_CLR_CHAN] && mem_ff[OFS_LCV_SEL][3:0] == 4'(c)))) begin
        nxt_count[c] = 16'h0000;
      end
      if (violation_i[c] && nxt_count[c] != COUNT_MAX) begin
        nxt_count[c] = nxt_count[c] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        count_ff[c] <= 16'h0000;
      end
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ******************************************************************
  // Channel decode and line routing.
  // ******************************************************************
  // Each channel reads its own sixteen-byte window.
  always_comb begin
    logic [7:0] r0;
    logic [7:0] r1;
    logic [4:0] code;
    r0 = 8'h00;
    r1 = 8'h00;
    code = 5'h00;
    for (int c = 0; c < NUM_CHAN; c++) begin
      r0   = mem_ff[c * 16 + int'(SUB_PATTERN)];  // [RQ10]
      r1   = mem_ff[c * 16 + int'(SUB_TERM)];
      code = r0[CODE_MSB:0];  // [RQ6]
      nxt_cfg[c].qrss      = r0[BIT_QRSS];  // [RQ1]
      nxt_cfg[c].route_rx  = r0[BIT_ROUTE];
      nxt_cfg[c].rx_power  = r0[BIT_RECEIVER_POWER_ON] & rx_en_sync_ff;  // [RQ4] [RQ5]
      nxt_cfg[c].mode      = LM_NONE;
      nxt_cfg[c].build_out = 3'h0;
      nxt_cfg[c].arbitrary = 1'b0;
      nxt_cfg[c].hdb3      = 1'b0;
      nxt_cfg[c].cable     = IMP_100;
      if (code >= CODE_T1_FIRST && code <= CODE_T1_LAST) begin  // [RQ7]
        nxt_cfg[c].mode      = LM_T1;
        nxt_cfg[c].build_out = 3'(code - CODE_T1_FIRST);
      end else if (code == CODE_T1_ARB) begin  // [RQ7]
        nxt_cfg[c].mode      = LM_T1;
        nxt_cfg[c].arbitrary = 1'b1;
      end else if (code == CODE_E1_COAX || code == CODE_E1_TP) begin  // [RQ8]
        nxt_cfg[c].mode  = LM_E1;
        nxt_cfg[c].hdb3  = 1'b1;
        nxt_cfg[c].cable = (code == CODE_E1_COAX) ? IMP_75 : IMP_120;
      end
      nxt_cfg[c].impedance = liucfg_imp_t'(r1[IMP_MSB:IMP_LSB]);  // [RQ9]
      nxt_cfg[c].jitter    = r1[JA_MSB] ? JA_RX : (r1[JA_LSB] ? JA_TX : JA_OFF);  // [RQ12]
      nxt_cfg[c].rx_term   = r1[BIT_RX_TERM];
      nxt_cfg[c].tx_term   = r1[BIT_TX_TERM];
    end
  end

  // Generator steering; with the route bit at zero and no generator the
  // channel is in plain pass-through.
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      nxt_pwr[c]  = nxt_cfg[c].rx_power;  // [RQ5]
      nxt_tip[c]  = tx_pos_i[c];
      nxt_ring[c] = tx_neg_i[c];
      nxt_receive_positive_data[c] = rx_pos_i[c];
      nxt_receive_negative_data[c] = rx_neg_i[c];
      if (generator_enable_i[c] && !cfg_ff[c].route_rx) begin  // [RQ2] [RQ3]
        nxt_tip[c]  = generator_bit_i[c];
        nxt_ring[c] = ~generator_bit_i[c];
      end else if (generator_enable_i[c]) begin  // [RQ2]
        nxt_receive_positive_data[c] = generator_bit_i[c];
        nxt_receive_negative_data[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        cfg_ff[c] <= '0;
      end
      pwr_ff  <= 8'h00;
      tip_ff  <= 8'h00;
      ring_ff <= 8'h00;
      receive_positive_data_ff <= 8'h00;
      receive_negative_data_ff <= 8'h00;
    end else begin
      cfg_ff  <= nxt_cfg;
      pwr_ff  <= nxt_pwr;
      tip_ff  <= nxt_tip;
      ring_ff <= nxt_ring;
      receive_positive_data_ff <= nxt_receive_positive_data;
      receive_negative_data_ff <= nxt_receive_negative_data;
    end
  end

  // ******************************************************************
  // Outputs.
  // ******************************************************************
  assign data_o                      = rdata_ff;
  assign data_oe_o                   = (state_ff == BUS_HOLD) && read_ff;
  assign dtack_n_o                   = (state_ff != BUS_HOLD);
  assign chan_cfg_o                  = cfg_ff;
  assign receiver_power_on_o         = pwr_ff;
  assign transmit_line_tip_o         = tip_ff;
  assign transmit_line_ring_o        = ring_ff;
  assign receive_positive_data_o     = receive_positive_data_ff;
  assign receive_negative_data_o     = receive_negative_data_ff;
  assign e1_arbitrary_pulse_enable_o = mem_ff[OFS_E1_ARB][BIT_E1_ARB];

endmodule
`default_nettype wire

// File: testbench/liucfg_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Checker on channel 0 settings and line routing.
// ****
module liucfg_checker (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    receiver_enable_i,
  input wire logic [7:0]              generator_enable_i,
  input wire logic [7:0]              generator_bit_i,
  input wire logic [7:0]              tx_pos_i,
  input wire logic [7:0]              tx_neg_i,
  input wire logic [7:0]              rx_pos_i,
  input wire logic [7:0]              rx_neg_i,
  input wire liucfg_pkg::liucfg_chan_t chan_cfg_o [8],
  input wire logic [7:0]              receiver_power_on_o,
  input wire logic [7:0]              transmit_line_tip_o,
  input wire logic [7:0]              transmit_line_ring_o,
  input wire logic [7:0]              receive_positive_data_o,
  input wire logic [7:0]              receive_negative_data_o
);
  import liucfg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Generator running on channel 0 towards each destination.
  sequence gen_rx_s;
    generator_enable_i[0] && chan_cfg_o[0].route_rx;
  endsequence
  sequence gen_tx_s;
    generator_enable_i[0] && !chan_cfg_o[0].route_rx;
  endsequence
  reset_clear_a: assert property ($fell(rst_i) |-> receiver_power_on_o == 8'h00
    && chan_cfg_o[0].mode == LM_NONE)
    else $error("outputs not cleared by reset");
  rx_forced_off_a: assert property (!receiver_enable_i [*4] |-> receiver_power_on_o == 8'h00)
    else $error("receiver on while enable pin low");
  route_rx_a: assert property (gen_rx_s |=> !receive_negative_data_o[0]
    && receive_positive_data_o[0] == $past(generator_bit_i[0]))
    else $error("generator not on receive outputs");
  route_tx_a: assert property (gen_tx_s |=> transmit_line_tip_o[0] == $past(generator_bit_i[0])
    && transmit_line_ring_o[0] != $past(generator_bit_i[0]))
    else $error("generator not on line outputs");
  pass_data_a: assert property (!generator_enable_i[0] |=> transmit_line_tip_o[0] == $past(tx_pos_i[0])
    && transmit_line_ring_o[0] == $past(tx_neg_i[0])
    && receive_positive_data_o[0] == $past(rx_pos_i[0])
    && receive_negative_data_o[0] == $past(rx_neg_i[0]))
    else $error("data not passed through");
  t1_mode_a: assert property (chan_cfg_o[0].mode == LM_T1 |-> chan_cfg_o[0].cable == IMP_100
    && !chan_cfg_o[0].hdb3)
    else $error("wrong T1 decode");
  e1_mode_a: assert property (chan_cfg_o[0].mode == LM_E1 |-> chan_cfg_o[0].hdb3
    && !chan_cfg_o[0].arbitrary && chan_cfg_o[0].cable inside {IMP_75, IMP_120})
    else $error("wrong E1 decode");
  jitter_code_a: assert property (chan_cfg_o[0].jitter != 2'h3)
    else $error("bad jitter path code");
endmodule
bind liucfg_regs liucfg_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .receiver_enable_i(receiver_enable_i),
  .generator_enable_i(generator_enable_i), .generator_bit_i(generator_bit_i), .tx_pos_i(tx_pos_i),
  .tx_neg_i(tx_neg_i), .rx_pos_i(rx_pos_i), .rx_neg_i(rx_neg_i), .chan_cfg_o(chan_cfg_o),
  .receiver_power_on_o(receiver_power_on_o),
  .transmit_line_tip_o(transmit_line_tip_o), .transmit_line_ring_o(transmit_line_ring_o),
  .receive_positive_data_o(receive_positive_data_o), .receive_negative_data_o(receive_negative_data_o));
`default_nettype wire

// File: testbench/liucfg_host.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Host processor model on the asynchronous register port.
// ****
module liucfg_host (
  input  wire logic              clk_i,
  input  wire logic [7:0]        data_i,
  input  wire logic              dtack_n_i,
  output liucfg_pkg::liucfg_bus_t bus_o,
  output logic                   rd_valid_o,
  output logic [7:0]             rd_data_o,
  output logic                   err_o
);
  import liucfg_pkg::*;
  // Idle bus at time zero.
  initial begin
    bus_o = '{cs_n: 1'b1, as_n: 1'b1, ds_n: 1'b1, rd_wr_n: 1'b1, addr: 8'h00, data: 8'h00};
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
    err_o = 1'b0;
  end
  // One cycle: address strobe, then data strobe held until acknowledge, then release.
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    bus_o <= '{cs_n: 1'b0, as_n: 1'b0, ds_n: 1'b1, rd_wr_n: rd, addr: a, data: rd ? ~bus_o.data : d};
    @(posedge clk_i);
    bus_o.ds_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (dtack_n_i !== 1'b0 && n < 20);
    err_o <= err_o | (n >= 20);
    rd_valid_o <= rd;
    rd_data_o <= data_i;
    // Released lines show inverted values so a stale level cannot pass.
    bus_o <= '{cs_n: 1'b1, as_n: 1'b1, ds_n: 1'b1, rd_wr_n: 1'b1, addr: ~a, data: ~bus_o.data};
    @(posedge clk_i);
    rd_valid_o <= 1'b0;
    n = 0;
    while (dtack_n_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    err_o <= err_o | (n >= 20);
  endtask
endmodule
`default_nettype wire

// File: testbench/liu_channel_global_config_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Self-checking bench for the register bank.
// ****
module liu_channel_global_config_regs_test;
  import liucfg_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         rx_en = 1'b0;
  logic [7:0]   viol = 8'h00, gen_en = 8'h00, gen_bit = 8'h00, tx_pos = 8'h00, tx_neg = 8'h00;
  logic [7:0]   rx_pos = 8'h00, rx_neg = 8'h00, power, tip, ring, receive_positive_data, receive_negative_data, rdata, h_data;
  logic         oe, dtack_n, e1arb, h_valid, h_err;
  liucfg_bus_t  bus;
  liucfg_chan_t cfg [8];
  logic [7:0]   exp_q [$];
  logic [31:0]  rs = 32'h3C2D758A, r = 32'h3C2D758A;
  int           n_fail = 0, samples_checked = 0, cycles = 0;
  logic [23:0]  tbl [7] = '{24'h03FF3E, 24'h05FF00, 24'h80FFFB, 24'hC0FF01, 24'h90A5A5, 24'hFE00A5, 24'h8EFF00};
  logic [15:0]  cab [8] = '{16'h0810, 16'h0910, 16'h0A10, 16'h0B10, 16'h0C10, 16'h0D14, 16'h1C2A, 16'h1D2B};

  liucfg_regs #(.DEVICE_IDENTIFIER(8'hA5), .DEVICE_REV(8'h01)) dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
    .data_o(rdata), .data_oe_o(oe), .dtack_n_o(dtack_n), .receiver_enable_i(rx_en), .violation_i(viol),
    .generator_enable_i(gen_en), .generator_bit_i(gen_bit), .tx_pos_i(tx_pos), .tx_neg_i(tx_neg),
    .rx_pos_i(rx_pos), .rx_neg_i(rx_neg), .chan_cfg_o(cfg), .receiver_power_on_o(power),
    .transmit_line_tip_o(tip), .transmit_line_ring_o(ring), .receive_positive_data_o(receive_positive_data),
    .receive_negative_data_o(receive_negative_data), .e1_arbitrary_pulse_enable_o(e1arb));
  liucfg_host host (.clk_i(clk_i), .data_i(rdata), .dtack_n_i(dtack_n), .bus_o(bus), .rd_valid_o(h_valid),
    .rd_data_o(h_data), .err_o(h_err));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    samples_checked++;
    if (seen !== expd) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b1, a, 8'h00);
  endtask

  // Clock and line data from the shift register.
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    rs = lfsr(rs);
    {gen_bit, tx_pos, rx_pos, tx_neg} <= rs;
    rx_neg <= ~rs[7:0];
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  // Read results are matched against the oldest noted value.
  always @(posedge clk_i) begin
    if (h_valid === 1'b1) check(16'({oe, h_data}), 16'({1'b1, exp_q.pop_front()}));
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 8; c++) rd(8'(c * 16), 8'h00);
    rd(OFS_DEV_ID, 8'hA5);
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      r = lfsr(r);
      // Route and power bits stay clear while no generator runs.
      wr(8'(c * 16), r[7:0] & 8'h9F);
      wr(8'(c * 16 + 1), r[15:8]);
      rd(8'(c * 16), r[7:0] & 8'h9F);
      rd(8'(c * 16 + 1), r[15:8]);
    end
    check(16'({cfg[7].qrss, cfg[7].rx_term, cfg[7].tx_term}), 16'({r[7], r[15], r[14]}));
    $display("test channel blocks done");
    for (int i = 0; i < 7; i++) begin
      wr(tbl[i][23:16], tbl[i][15:8]);
      rd(tbl[i][23:16], tbl[i][7:0]);
    end
    check(16'(e1arb), 16'h0001);
    $display("test masks done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, cab[i][15:8]);
      check(16'({cfg[0].mode, cfg[0].hdb3, cfg[0].arbitrary, cfg[0].cable}), 16'(cab[i][7:0]));
      check(16'(cfg[0].build_out), 16'(i < 5 ? i : 0));
    end
    $display("test cable codes done");
    for (int i = 0; i < 16; i++) begin
      wr(8'h01, 8'(i << 2));
      check(16'({cfg[0].impedance, cfg[0].jitter}), 16'({i[3:2], i[1] ? 2'h2 : i[1:0]}));
    end
    $display("test impedance and jitter done");
    wr(8'h00, 8'h20);
    wr(8'h10, 8'h20);
    repeat (5) @(posedge clk_i);
    check(16'(power), 16'h0000);
    rx_en <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(16'(power), 16'h0003);
    rx_en <= 1'b0;
    repeat (5) @(posedge clk_i);
    check(16'(power), 16'h0000);
    $display("test receiver power done");
    // The route bit only moves while the generator runs.
    gen_en <= 8'h01;
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, i ? 8'h48 : 8'h08);
      repeat (20) @(posedge clk_i);
      if (i == 1) check(16'(receive_negative_data[0]), 16'h0000);
      else check(16'(tip[0] ^ ring[0]), 16'h0001);
    end
    wr(8'h00, 8'h08);
    gen_en <= 8'h00;
    $display("test generator routing done");
    wr(OFS_LCV_CTRL, 8'h10);
    wr(OFS_LCV_CTRL, 8'h00);
    wr(OFS_LCV_SEL, 8'h03);
    repeat (5) begin
      viol <= 8'h08;
      @(posedge clk_i);
      viol <= 8'h00;
      @(posedge clk_i);
    end
    rd(OFS_LCV_READ, 8'h05);
    wr(OFS_LCV_CTRL, 8'h04);
    rd(OFS_LCV_READ, 8'h00);
    wr(OFS_LCV_CTRL, 8'h01);
    rd(OFS_LCV_READ, 8'h00);
    $display("test violation counter done");
    repeat (5) @(posedge clk_i);
    check(16'(h_err), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
